/* core/dps_sram_block.v */
// Dual-port 256-bit memory block, 32x8 or 64x4, with pin-driven port clocks
`include "dps_map.vh"

// What this block does
// [RULE_01] Holds 256 bits, organised as 32 bytes or 64 nibbles.
// [RULE_02] Read port and write port run independently with separate addresses.
// [RULE_03] Nibble mode uses six address bits to pick one of 64 locations.
// [RULE_04] Byte mode ignores address bit five on both ports, 32 locations.
// [RULE_05] Each port has its own clock with independently selectable active edge.
// [RULE_06] Eight-bit write data in, eight-bit read data out; nibble mode uses low four.
// [RULE_07] Outside logic cascades blocks, sharing or decoding addresses and clocks.
// [RULE_08] Active write edge stores data; active read edge presents addressed contents.
module dps_sram_block (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_byte_mode,
   input wire i_write_clk,
   input wire i_write_clk_fall,
   input wire [5:0] i_write_addr,
   input wire [7:0] i_write_data_in,
   input wire i_read_clk,
   input wire i_read_clk_fall,
   input wire [5:0] i_read_addr,
   output reg [7:0] o_read_data,
   output reg o_read_strobe
);

   // ==========================================================
   // Reset release
   // Assertion stays asynchronous; release is retimed so that every flop past the
   // synchronisers leaves reset on the same clock edge; the synchronisers use i_rst_n.
   wire rst_sync_n;

   dps_sync #(
      .W(1)
   ) u_rst_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async(`DPS_BIT_SET),
      .o_sync(rst_sync_n)
   );

   // ==========================================================
   // Pin synchronisation
   // Clocks, addresses and data share one synchroniser so they stay aligned.
   wire [`DPS_SYNC_W-1:0] pins_async;
   wire [`DPS_SYNC_W-1:0] pins_s;

   assign pins_async = {i_write_data_in, i_read_addr, i_write_addr, i_read_clk_fall,
                        i_write_clk_fall, i_byte_mode, i_read_clk, i_write_clk};

   dps_sync #(
      .W(`DPS_SYNC_W)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async(pins_async),
      .o_sync(pins_s)
   );

   wire wclk_s;
   wire rclk_s;
   wire byte_s;
   wire wfall_s;
   wire rfall_s;
   wire [`DPS_AW-1:0] waddr_s;
   wire [`DPS_AW-1:0] raddr_s;
   wire [`DPS_DW-1:0] wdata_s;

   assign wclk_s = pins_s[`DPS_S_WCLK];
   assign rclk_s = pins_s[`DPS_S_RCLK];
   assign byte_s = pins_s[`DPS_S_BYTE];
   assign wfall_s = pins_s[`DPS_S_WFALL];
   assign rfall_s = pins_s[`DPS_S_RFALL];
   assign waddr_s = pins_s[`DPS_S_WA_MSB:`DPS_S_WA_LSB];
   assign raddr_s = pins_s[`DPS_S_RA_MSB:`DPS_S_RA_LSB];
   assign wdata_s = pins_s[`DPS_S_WD_MSB:`DPS_S_WD_LSB];

   // ==========================================================
   // Active-edge detection per port
   reg wclk_prev_q;
   reg rclk_prev_q;
   wire wclk_rise;
   wire wclk_fallen;
   wire rclk_rise;
   wire rclk_fallen;
   wire write_evt;
   wire read_evt;

   // Prev flops reset low: a pin clock high at release reads as a rising edge
   always @(posedge i_sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wclk_prev_q <= `DPS_BIT_RST;
         rclk_prev_q <= `DPS_BIT_RST;
      end else begin
         wclk_prev_q <= wclk_s;
         rclk_prev_q <= rclk_s;
      end
   end

   assign wclk_rise = wclk_s & ~wclk_prev_q;
   assign wclk_fallen = ~wclk_s & wclk_prev_q;
   assign rclk_rise = rclk_s & ~rclk_prev_q;
   assign rclk_fallen = ~rclk_s & rclk_prev_q;
   // Polarity chosen separately for each port
   assign write_evt = wfall_s ? wclk_fallen : wclk_rise; // [RULE_05]
   assign read_evt = rfall_s ? rclk_fallen : rclk_rise; // [RULE_05]

   // ==========================================================
   // Address decode
   // Row index is the byte address; in nibble mode bit zero picks the half.
   reg [`DPS_ROW_AW-1:0] wrow;
   reg [`DPS_ROW_AW-1:0] rrow;
   reg wnib_hi;
   reg rnib_hi;

   always @* begin
      if (byte_s) begin
         wrow = waddr_s[`DPS_ROW_MSB:0]; // [RULE_04]
         rrow = raddr_s[`DPS_ROW_MSB:0]; // [RULE_04]
         wnib_hi = 1'b0;
         rnib_hi = 1'b0;
      end else begin
         wrow = waddr_s[`DPS_ADDR_MSB:`DPS_NROW_LSB]; // [RULE_03]
         rrow = raddr_s[`DPS_ADDR_MSB:`DPS_NROW_LSB]; // [RULE_03]
         wnib_hi = waddr_s[`DPS_NIB_SEL]; // [RULE_03]
         rnib_hi = raddr_s[`DPS_NIB_SEL]; // [RULE_03]
      end
   end

   // ==========================================================
   // Write lane decode
   // One enable per row and per nibble lane; byte mode opens both lanes.
   // A nibble write leaves the other half of its row untouched.
   reg [`DPS_ROWS-1:0] wrow_en;
   reg wlane_lo;
   reg wlane_hi;
   reg [`DPS_DW-1:0] wbyte;
   integer r;

   always @* begin
      wrow_en = {`DPS_ROWS{1'b0}};
      for (r = 0; r < `DPS_ROWS; r = r + 1) begin
         wrow_en[r] = write_evt & (wrow == r[`DPS_ROW_AW-1:0]); // [RULE_08]
      end
      if (byte_s) begin
         wlane_lo = `DPS_BIT_SET;
         wlane_hi = `DPS_BIT_SET;
         wbyte = wdata_s; // [RULE_06]
      end else begin
         // Nibble copied into both halves so either lane can take it
         wlane_lo = ~wnib_hi; // [RULE_03]
         wlane_hi = wnib_hi; // [RULE_03]
         wbyte = {wdata_s[`DPS_LO_MSB:`DPS_LO_LSB], wdata_s[`DPS_LO_MSB:`DPS_LO_LSB]}; // [RULE_06]
      end
   end

   // ==========================================================
   // Storage: 32 rows of 8 flip-flops, 256 bits in all
   reg [`DPS_DW-1:0] mem_q [0:`DPS_ROWS-1]; // [RULE_01]
   integer i;

   always @(posedge i_sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         for (i = 0; i < `DPS_ROWS; i = i + 1) begin
            mem_q[i] <= `DPS_BYTE_RST;
         end
      end else begin
         for (i = 0; i < `DPS_ROWS; i = i + 1) begin
            if (wrow_en[i] & wlane_hi) begin
               mem_q[i][`DPS_HI_MSB:`DPS_HI_LSB] <= wbyte[`DPS_HI_MSB:`DPS_HI_LSB];
            end
            if (wrow_en[i] & wlane_lo) begin
               mem_q[i][`DPS_LO_MSB:`DPS_LO_LSB] <= wbyte[`DPS_LO_MSB:`DPS_LO_LSB];
            end
         end
      end
   end

   // ==========================================================
   // Read port
   // Read and write events in the same cycle: read returns the old contents.
   reg [`DPS_DW-1:0] rrow_data;
   reg [`DPS_DW-1:0] read_d;

   integer k;

   // Flat mux over the rows, the same shape as the write enables
   always @* begin
      rrow_data = `DPS_BYTE_RST;
      for (k = 0; k < `DPS_ROWS; k = k + 1) begin
         if (rrow == k[`DPS_ROW_AW-1:0]) begin
            rrow_data = mem_q[k];
         end
      end
   end

   always @* begin
      if (byte_s) begin
         read_d = rrow_data;
      end else if (rnib_hi) begin
         read_d = {`DPS_NIB_RST, rrow_data[`DPS_HI_MSB:`DPS_HI_LSB]}; // [RULE_06]
      end else begin
         read_d = {`DPS_NIB_RST, rrow_data[`DPS_LO_MSB:`DPS_LO_LSB]}; // [RULE_06]
      end
   end

   // Read side never looks at write events, so the ports stay independent
   always @(posedge i_sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_read_data <= `DPS_BYTE_RST;
         o_read_strobe <= `DPS_BIT_RST;
      end else begin
         o_read_strobe <= read_evt;
         if (read_evt) begin // [RULE_02]
            o_read_data <= read_d; // [RULE_08]
         end
      end
   end

endmodule

/* inc/dps_map.vh */
// Constants for the dual-port memory block: geometry, field positions, reset values
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// ==========================================================
// Geometry
`define DPS_ROWS 32
`define DPS_ROW_AW 5
`define DPS_AW 6
`define DPS_DW 8
`define DPS_NW 4

// ==========================================================
// Field positions inside the six-bit address
`define DPS_ADDR_MSB 5
`define DPS_ROW_MSB 4
`define DPS_NIB_SEL 0
`define DPS_NROW_LSB 1

// ==========================================================
// Field positions inside the byte
`define DPS_LO_MSB 3
`define DPS_LO_LSB 0
`define DPS_HI_MSB 7
`define DPS_HI_LSB 4

// ==========================================================
// Synchroniser bundle layout
`define DPS_SYNC_W 25
`define DPS_S_WCLK 0
`define DPS_S_RCLK 1
`define DPS_S_BYTE 2
`define DPS_S_WFALL 3
`define DPS_S_RFALL 4
`define DPS_S_WA_LSB 5
`define DPS_S_WA_MSB 10
`define DPS_S_RA_LSB 11
`define DPS_S_RA_MSB 16
`define DPS_S_WD_LSB 17
`define DPS_S_WD_MSB 24

// ==========================================================
// Reset values
`define DPS_BYTE_RST 8'h00
`define DPS_NIB_RST 4'h0
`define DPS_BIT_RST 1'b0
`define DPS_BIT_SET 1'b1
`define DPS_BUS_RST 25'h0000000

`endif

/* core/dps_sync.v */
// Two-stage synchroniser for a bundle of pin inputs
`include "dps_map.vh"

module dps_sync #(
   parameter W = 1
) (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);

   reg [W-1:0] meta_q;

   // ==========================================================
   // First stage is read by the second stage only
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

/* verification/dps_sram_checker.sv */
// Port assertions for the memory block
module dps_sram_checker (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_byte_mode,
   input wire i_read_clk,
   input wire i_read_clk_fall,
   input wire [7:0] o_read_data,
   input wire o_read_strobe
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   chk_strobe_pulse: assert property (o_read_strobe |=> !o_read_strobe)
      else $error("strobe too long");
   chk_data_hold: assert property (!o_read_strobe |-> $stable(o_read_data))
      else $error("data moved");
   chk_nib_upper: assert property (o_read_strobe && !i_byte_mode |-> o_read_data[7:4] == 4'h0)
      else $error("upper nibble");
   chk_rise_read: assert property ($rose(i_read_clk) && !i_read_clk_fall |-> ##[1:4] o_read_strobe)
      else $error("no rise read");
   chk_fall_read: assert property ($fell(i_read_clk) && i_read_clk_fall |-> ##[1:4] o_read_strobe)
      else $error("no fall read");
   chk_wrong_edge: assert property ($rose(i_read_clk) && i_read_clk_fall |=> !o_read_strobe [*3])
      else $error("wrong edge");
   chk_read_idle: assert property ($stable(i_read_clk) [*8] |=> !o_read_strobe)
      else $error("stray read");
   cover property (o_read_strobe && i_byte_mode);
   cover property (o_read_strobe && !i_byte_mode);
   cover property ($fell(i_read_clk) && i_read_clk_fall);
endmodule
bind dps_sram_block dps_sram_checker chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
   .i_byte_mode(i_byte_mode), .i_read_clk(i_read_clk), .i_read_clk_fall(i_read_clk_fall),
   .o_read_data(o_read_data), .o_read_strobe(o_read_strobe));

/* verification/dps_user_model.sv */
// User logic driving both memory ports
module dps_user_model (
   input wire logic i_sys_clk,
   output logic o_wclk = 1'b0,
   output logic o_rclk = 1'b0,
   output logic [5:0] o_wa = 6'h00,
   output logic [7:0] o_wd = 8'h00,
   output logic [5:0] o_ra = 6'h00
);
   timeunit 1ns;
   timeprecision 1ns;
   // Phases of 4 cycles keep address and data steady around either edge
   task automatic pulse(input bit w);
      repeat (4) @(negedge i_sys_clk);
      if (w) o_wclk = 1'b1;
      else o_rclk = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      if (w) o_wclk = 1'b0;
      else o_rclk = 1'b0;
      repeat (4) @(negedge i_sys_clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      o_wa = a;
      o_wd = d;
      pulse(1'b1);
   endtask
   task automatic rd(input logic [5:0] a);
      o_ra = a;
      pulse(1'b0);
   endtask
endmodule

/* verification/dps_sram_block_tb_top.sv */
// Testbench for the memory block
module dps_sram_block_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode = 1'b0;
   logic wpol = 1'b0;
   logic rpol = 1'b0;
   logic wclk, rclk, strobe;
   logic [5:0] wa, ra;
   logic [7:0] wd, rdata, rdata_w;
   int n_mismatch = 0;
   int total_checks = 0;
   int n_strobe = 0;
   always #5 clk = ~clk;
   // Strobes counted away from the edge that launches them
   always @(negedge clk) if (strobe === 1'b1) n_strobe++;
   dps_sram_block dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_byte_mode(mode),
      .i_write_clk(wclk), .i_write_clk_fall(wpol), .i_write_addr(wa), .i_write_data_in(wd),
      .i_read_clk(rclk), .i_read_clk_fall(rpol), .i_read_addr(ra), .o_read_data(rdata),
      .o_read_strobe(strobe));
   // Second block shares clocks and addresses to widen the word to 16 bits
   dps_sram_block dut_wide (.i_sys_clk(clk), .i_rst_n(rst_n), .i_byte_mode(mode),
      .i_write_clk(wclk), .i_write_clk_fall(wpol), .i_write_addr(wa), .i_write_data_in(~wd),
      .i_read_clk(rclk), .i_read_clk_fall(rpol), .i_read_addr(ra), .o_read_data(rdata_w),
      .o_read_strobe());
   dps_user_model um (.i_sys_clk(clk), .o_wclk(wclk), .o_rclk(rclk), .o_wa(wa),
      .o_wd(wd), .o_ra(ra));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Upper write nibble is junk and must be dropped
   task automatic t_nibble();
      for (int i = 0; i < 64; i++)
         um.wr(i[5:0], 8'(i * 7));
      for (int i = 0; i < 64; i++) begin
         um.rd(i[5:0]);
         chk(rdata, {4'h0, 4'(i * 7)});
      end
      $display("nibble test end");
   endtask
   // Write port on falling edges, read port on rising, both started together
   task automatic t_mixed();
      int base;
      base = n_strobe;
      wpol = 1'b1;
      fork
         um.wr(6'h05, 8'hfc);
         um.rd(6'h05);
      join
      chk(rdata, {4'h0, 4'(5 * 7)});
      um.rd(6'h05);
      chk(rdata, 8'h0c);
      chk(8'(n_strobe - base), 8'h02);
      wpol = 1'b0;
      $display("mixed test end");
   endtask
   // Falling edges, bit five differs between write and read
   task automatic t_byte();
      mode = 1'b1;
      wpol = 1'b1;
      rpol = 1'b1;
      for (int i = 0; i < 32; i++)
         um.wr({1'b1, i[4:0]}, 8'(i * 9 + 3));
      for (int i = 0; i < 32; i++) begin
         um.rd({1'b0, i[4:0]});
         chk(rdata, 8'(i * 9 + 3));
         chk(rdata_w, ~8'(i * 9 + 3));
      end
      mode = 1'b0;
      wpol = 1'b0;
      rpol = 1'b0;
      for (int i = 0; i < 4; i++) begin
         um.rd(6'(2 * i + 1));
         chk(rdata, {4'h0, 4'((i * 9 + 3) >> 4)});
      end
      $display("byte test end");
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_nibble();
      t_mixed();
      t_byte();
      results();
   end
   initial begin
      #100us;
      n_mismatch++;
      results();
   end
endmodule
